//--- sst_defines.vh
// sst_defines.vh: offsets, field positions, reset values and timing counts for the slave port tracker
// assumes a 100 MHz system clock and a 19.2k baud link of 11-bit characters
`ifndef SST_DEFINES_VH
`define SST_DEFINES_VH

// ----------------------------------------
// status table mirror offsets
// ----------------------------------------
`define SST_OFF_MSG_LO      16'h09c8
`define SST_OFF_MSG_HI      16'h09c9
`define SST_OFF_EVT_LO      16'h09ca
`define SST_OFF_EVT_HI      16'h09cb

// ----------------------------------------
// function codes, log byte fields
// ----------------------------------------
`define SST_FC_LOOPBACK     8'h08
`define SST_FC_EVLOG        8'h0c
`define SST_FC_ERR_BIT      7
`define SST_LOG_DIR_BIT     7
`define SST_LOG_ERR_BIT     1
`define SST_LOG_ADR_BIT     6
`define SST_CNT_RESET       16'h0000
`define SST_BUSY_ONES       16'hffff

// ----------------------------------------
// modes of the controller
// ----------------------------------------
`define SST_MODE_PROGRAM    2'h0
`define SST_MODE_DISABLE    2'h1
`define SST_MODE_RUNEDIT    2'h2

// ----------------------------------------
// access classes
// ----------------------------------------
`define SST_CLS_STATUS      2'h0
`define SST_CLS_IOREG       2'h1
`define SST_CLS_REALOUT     2'h2
`define SST_CLS_INTERNAL    2'h3

// ----------------------------------------
// timing: character time in us, cycles derived from it
// ----------------------------------------
`define SST_CLK_NS          10
`define SST_CHAR_NS         573
`define SST_CHAR_US         573
`define SST_CHAR_CYC        ((`SST_CHAR_US * 1000 + `SST_CLK_NS - 1) / `SST_CLK_NS)
`define SST_CRC_POLY        16'ha001

`endif

//--- sst_slave_tracker.v
// sst_slave_tracker.v: exchange tracking, event log and line turnaround of the serial slave port
// assumes character strobes from a uart on clk_i, and slot grants from the controller scan engine
`timescale 1ns/100ps
`include "sst_defines.vh"

module sst_slave_tracker #(
	parameter [31:0] CHAR_CYC = `SST_CHAR_CYC
) (
	// clock and reset
	input  wire        clk_i,
	input  wire        rst_i,
	// serial receive side, from the uart
	input  wire        rx_char_i,
	input  wire [7:0]  rx_data_i,
	input  wire        rx_frm_err_i,
	input  wire        rx_par_err_i,
	input  wire        rx_ovr_err_i,
	input  wire        rx_addr_ok_i,
	input  wire        line_idle_i,
	// command decode, valid with the end of a message
	input  wire [7:0]  cmd_func_i,
	input  wire [1:0]  cmd_class_i,
	input  wire        cmd_write_i,
	input  wire        cmd_bad_i,
	input  wire        cmd_single_wr_i,
	input  wire        cmd_read_i,
	// scan engine slot and controller mode
	input  wire        scan_access_slot_i,
	input  wire        slot_done_i,
	input  wire        access_ok_i,
	input  wire [1:0]  ctl_mode_i,
	// status table fetch
	input  wire        status_fetch_operation_i,
	input  wire [15:0] status_addr_i,
	// transmit side
	input  wire        resp_last_i,
	input  wire        tx_char_done_i,
	// outputs
	output reg         rx_en_o,
	output reg         tx_en_o,
	output reg         rts_o,
	output reg         tx_start_o,
	output reg         slot_req_o,
	output reg         single_slot_o,
	output reg         access_ok_o,
	output reg  [7:0]  resp_func_o,
	output reg  [15:0] busy_word_o,
	output reg  [15:0] msg_cnt_o,
	output reg  [15:0] evt_cnt_o,
	output reg  [7:0]  status_data_o,
	output reg  [7:0]  log_data_o,
	output reg         log_valid_o,
	output reg  [15:0] crc_o
);

// ----------------------------------------
// states
// ----------------------------------------
localparam [6:0] ST_RX   = 7'h01;
localparam [6:0] ST_PROC = 7'h02;
localparam [6:0] ST_RTS  = 7'h04;
localparam [6:0] ST_TX   = 7'h08;
localparam [6:0] ST_TAIL = 7'h10;
localparam [6:0] ST_LOG  = 7'h20;
localparam [6:0] ST_WAIT = 7'h40;

reg  [6:0]  st_r;
reg  [31:0] tmr_r;
reg  [7:0]  mem [0:63];
reg  [5:0]  wr_ptr_r;
reg  [5:0]  rd_ptr_r;
reg  [6:0]  rd_cnt_r;
reg         msg_err_r;
reg         in_msg_r;
reg         rx_s1_r;
reg         rx_s2_r;
reg         idl_s1_r;
reg         idl_s2_r;
reg  [1:0]  slots_r;
reg         first_r;
integer     i;

// crc update for one byte, used for the receive check
function [15:0] crc_byte;
	input [15:0] c;
	input [7:0]  d;
	integer      k;
	reg   [15:0] t;
	begin
		t = c ^ {8'h00, d};
		for (k = 0; k < 8; k = k + 1) begin
			t = t[0] ? ((t >> 1) ^ `SST_CRC_POLY) : (t >> 1);
		end
		crc_byte = t;
	end
endfunction

// mode gate per access class
function allow;
	input [1:0] cls;
	input       wr;
	input [1:0] md;
	begin
		if (cls == `SST_CLS_STATUS || cls == `SST_CLS_INTERNAL) begin
			allow = 1'b1;
		end else if (cls == `SST_CLS_IOREG) begin
			allow = wr ? (md == `SST_MODE_RUNEDIT) : (md != `SST_MODE_PROGRAM);
		end else begin
			allow = wr & (md == `SST_MODE_RUNEDIT);
		end
	end
endfunction

wire [7:0] rx_log = {1'b0, ~rx_addr_ok_i, 4'h0,
	rx_frm_err_i | rx_par_err_i | rx_ovr_err_i, 1'b0};
wire       immed  = (cmd_func_i == `SST_FC_LOOPBACK) || (cmd_func_i == `SST_FC_EVLOG) || cmd_bad_i;
wire       ok_now = allow(cmd_class_i, cmd_write_i, ctl_mode_i);

// ----------------------------------------
// synchronise the character strobe and the raw line idle level
// ----------------------------------------
always @(posedge clk_i) begin
	if (rst_i) begin
		rx_s1_r  <= 1'b0;
		rx_s2_r  <= 1'b0;
		idl_s1_r <= 1'b1;
		idl_s2_r <= 1'b1;
	end else begin
		rx_s1_r  <= rx_char_i;
		rx_s2_r  <= rx_s1_r;
		idl_s1_r <= line_idle_i;
		idl_s2_r <= idl_s1_r;
	end
end

// ----------------------------------------
// main sequencer
// ----------------------------------------
always @(posedge clk_i) begin
	if (rst_i) begin
		st_r <= ST_RX;
		tmr_r <= 32'h0000_0000;
		wr_ptr_r <= 6'h00;
		rd_ptr_r <= 6'h00;
		rd_cnt_r <= 7'h00;
		msg_err_r <= 1'b0;
		in_msg_r <= 1'b0;
		slots_r <= 2'h0;
		first_r <= 1'b0;
		rx_en_o <= 1'b1;
		tx_en_o <= 1'b0;
		rts_o <= 1'b0;
		tx_start_o <= 1'b0;
		slot_req_o <= 1'b0;
		single_slot_o <= 1'b0;
		access_ok_o <= 1'b0;
		resp_func_o <= 8'h00;
		busy_word_o <= `SST_CNT_RESET;
		msg_cnt_o <= `SST_CNT_RESET;
		evt_cnt_o <= `SST_CNT_RESET;
		status_data_o <= 8'h00;
		log_data_o <= 8'h00;
		log_valid_o <= 1'b0;
		crc_o <= `SST_BUSY_ONES;
		for (i = 0; i < 64; i = i + 1) begin
			mem[i] <= 8'h00;
		end
	end else begin
		tx_start_o  <= 1'b0;
		log_valid_o <= 1'b0;
		// status table mirror, low byte first
		if (status_fetch_operation_i) begin
			if (status_addr_i == `SST_OFF_MSG_LO) begin
				status_data_o <= msg_cnt_o[7:0];
			end else if (status_addr_i == `SST_OFF_MSG_HI) begin
				status_data_o <= msg_cnt_o[15:8];
			end else if (status_addr_i == `SST_OFF_EVT_LO) begin
				status_data_o <= evt_cnt_o[7:0];
			end else if (status_addr_i == `SST_OFF_EVT_HI) begin
				status_data_o <= evt_cnt_o[15:8];
			end else begin
				status_data_o <= 8'h00;
			end
		end
		// transmit characters go to the log as well
		if (tx_char_done_i && st_r == ST_TX) begin
			mem[wr_ptr_r] <= 8'h80 >> (7 - `SST_LOG_DIR_BIT);
			wr_ptr_r <= wr_ptr_r + 6'h01;
		end
		case (st_r)
		ST_RX: begin
			if (rx_s2_r && rx_en_o) begin
				mem[wr_ptr_r] <= rx_log;
				wr_ptr_r <= wr_ptr_r + 6'h01;
				crc_o <= crc_byte(in_msg_r ? crc_o : `SST_BUSY_ONES, rx_data_i);
				msg_err_r <= (in_msg_r & msg_err_r) | ~rx_addr_ok_i | rx_frm_err_i | rx_par_err_i | rx_ovr_err_i;
				in_msg_r <= 1'b1;
				tmr_r <= 32'h0000_0000;
			end else if (in_msg_r && idl_s2_r) begin
				// a gap past three characters closes the message
				if (tmr_r >= 3 * CHAR_CYC) begin
					in_msg_r <= 1'b0;
					rx_en_o <= 1'b0;
					if (!msg_err_r && crc_o == 16'h0000) begin
						msg_cnt_o <= msg_cnt_o + 16'h0001;
						single_slot_o <= immed;
						slots_r <= immed ? 2'h0 : 2'h2;
						slot_req_o <= 1'b1;
						st_r <= ST_PROC;
					end else begin
						// crc, address or character error: no reply, host times out
						rx_en_o <= 1'b1;
					end
				end else begin
					tmr_r <= tmr_r + 32'h0000_0001;
				end
			end
		end
		ST_PROC: begin
			if (scan_access_slot_i) begin
				busy_word_o <= `SST_BUSY_ONES;
				first_r <= 1'b1;
				access_ok_o <= ok_now & ~cmd_bad_i;
				st_r <= ST_WAIT;
			end
		end
		ST_WAIT: begin
			if (slot_done_i) begin
				busy_word_o <= `SST_CNT_RESET;
				if (slots_r == 2'h0) begin
					slot_req_o <= 1'b0;
					if (cmd_bad_i || !access_ok_o) begin
						resp_func_o <= cmd_func_i | (8'h01 << `SST_FC_ERR_BIT);
					end else begin
						resp_func_o <= cmd_func_i;
						if (access_ok_i && (cmd_read_i || cmd_single_wr_i)) begin
							evt_cnt_o <= evt_cnt_o + 16'h0001;
						end
					end
					rts_o <= 1'b1;
					tmr_r <= 32'h0000_0000;
					st_r <= ST_RTS;
				end else begin
					slots_r <= slots_r - 2'h1;
					st_r <= ST_PROC;
				end
			end
		end
		ST_RTS: begin
			if (tmr_r >= CHAR_CYC - 1) begin
				tx_en_o <= 1'b1;
				tmr_r <= 32'h0000_0000;
				rd_ptr_r <= wr_ptr_r - 6'h01;
				rd_cnt_r <= 7'h00;
				if (cmd_func_i == `SST_FC_EVLOG && !cmd_bad_i) begin
					st_r <= ST_LOG;
				end else begin
					tx_start_o <= 1'b1;
					st_r <= ST_TX;
				end
			end else begin
				tmr_r <= tmr_r + 32'h0000_0001;
			end
		end
		ST_LOG: begin
			// one entry a cycle to the response builder, newest first
			log_data_o <= mem[rd_ptr_r];
			log_valid_o <= 1'b1;
			rd_ptr_r <= rd_ptr_r - 6'h01;
			rd_cnt_r <= rd_cnt_r + 7'h01;
			if (rd_cnt_r == 7'h3f) begin
				tx_start_o <= 1'b1;
				st_r <= ST_TX;
			end
		end
		ST_TX: begin
			if (tx_char_done_i && resp_last_i) begin
				tmr_r <= 32'h0000_0000;
				st_r <= ST_TAIL;
			end
		end
		ST_TAIL: begin
			if (tmr_r >= 4 * CHAR_CYC - 1) begin
				tx_en_o <= 1'b0;
				rts_o <= 1'b0;
				rx_en_o <= 1'b1;
				first_r <= 1'b0;
				st_r <= ST_RX;
			end else begin
				tmr_r <= tmr_r + 32'h0000_0001;
			end
		end
		default: st_r <= ST_RX;
		endcase
	end
end

endmodule

//--- sst_checker.sv
// sst_checker.sv: turnaround and counter assertions for the slave port tracker
// assumes a bind to sst_slave_tracker with CHAR_CYC handed on
`timescale 1ns/100ps
module sst_checker #(
	parameter [31:0] CHAR_CYC = 4
) (
	input wire        clk_i,
	input wire        rst_i,
	input wire        status_fetch_operation_i,
	input wire [15:0] status_addr_i,
	input wire        slot_done_i,
	input wire        resp_last_i,
	input wire        tx_char_done_i,
	input wire        rx_en_o,
	input wire        tx_en_o,
	input wire        rts_o,
	input wire        tx_start_o,
	input wire [15:0] busy_word_o,
	input wire [15:0] msg_cnt_o,
	input wire [15:0] evt_cnt_o,
	input wire [7:0]  status_data_o
);
	reg [15:0] mark_cnt;
	reg [15:0] tail_cnt;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// ----
	// mark counters, bounds for the line turnaround
	// ----
	always @(posedge clk_i) begin
		if (rst_i || !rts_o || tx_en_o)
			mark_cnt <= 16'h0000;
		else
			mark_cnt <= mark_cnt + 16'h0001;
		if (rst_i || (tx_char_done_i && resp_last_i))
			tail_cnt <= 16'h0000;
		else if (rts_o)
			tail_cnt <= tail_cnt + 16'h0001;
	end
	// ----
	// assertions
	// ----
	a_mark_before_tx: assert property ($rose(tx_en_o) |-> rts_o && mark_cnt >= CHAR_CYC)
		else $error("tx enabled early");
	a_start_in_tx: assert property (tx_start_o |-> tx_en_o && rts_o)
		else $error("start outside tx");
	a_tail_mark: assert property ($fell(rts_o) |-> tail_cnt >= 4 * CHAR_CYC - 1)
		else $error("tail mark short");
	a_turn_release: assert property ($fell(rts_o) |-> !tx_en_o && rx_en_o)
		else $error("bad release");
	a_busy_clear: assert property (slot_done_i |=> busy_word_o == 16'h0000)
		else $error("busy kept");
	a_evt_step: assert property ($changed(evt_cnt_o) |-> evt_cnt_o == $past(evt_cnt_o) + 16'h0001)
		else $error("evt step");
	a_msg_step: assert property ($changed(msg_cnt_o) |-> msg_cnt_o == $past(msg_cnt_o) + 16'h0001)
		else $error("msg step");
	a_fetch_low: assert property (status_fetch_operation_i && status_addr_i == 16'h09c8
		|=> status_data_o == msg_cnt_o[7:0])
		else $error("fetch low");
endmodule

bind sst_slave_tracker sst_checker #(.CHAR_CYC(CHAR_CYC)) sst_checker_inst (.*);

//--- sst_host_model.sv
// sst_host_model.sv: host master sending framed commands as character strobes
// assumes the tracker samples strobes on clk_i
`timescale 1ns/100ps
module sst_host_model #(
	parameter CHAR_CYC = 4
) (
	input  wire       clk_i,
	output reg        rx_char_o = 1'b0,
	output reg  [7:0] rx_data_o = 8'h00,
	output reg        frm_err_o = 1'b0,
	output reg        addr_ok_o = 1'b1,
	output reg        line_idle_o = 1'b1
);
	reg [15:0] crc;
	reg [7:0]  b [0:3];
	task send(input [7:0] a, input [7:0] f, input [2:0] ep, input aok);
		integer i;
		integer k;
		begin
			b[0] = a;
			b[1] = f;
			crc = 16'hffff;
			for (i = 0; i < 2; i = i + 1) begin
				crc = crc ^ {8'h00, b[i]};
				for (k = 0; k < 8; k = k + 1)
					crc = crc[0] ? (crc >> 1) ^ 16'ha001 : crc >> 1;
			end
			b[2] = crc[7:0];
			b[3] = crc[15:8];
			line_idle_o = 1'b0;
			for (i = 0; i < 4; i = i + 1) begin
				// one character time and one cycle apart, well under the gap limit
				repeat (CHAR_CYC) @(negedge clk_i);
				rx_data_o = b[i];
				frm_err_o = (ep == i);
				addr_ok_o = aok;
				rx_char_o = 1'b1;
				@(negedge clk_i) rx_char_o = 1'b0;
			end
			repeat (3) @(negedge clk_i);
			rx_data_o = ~rx_data_o;
			line_idle_o = 1'b1;
		end
	endtask
endmodule

//--- testbench.sv
// testbench.sv: exchanges, slots, log report and status fetch on the tracker
// assumes the host model and checker compiled first
`timescale 1ns/100ps
module testbench;
	localparam CC = 4;
	reg clk_i = 1'b0, rst_i = 1'b1, cmd_write_i = 1'b0, cmd_bad_i = 1'b0, cmd_single_wr_i = 1'b0;
	reg cmd_read_i = 1'b0, scan_access_slot_i = 1'b0, slot_done_i = 1'b0, access_ok_i = 1'b0;
	reg status_fetch_operation_i = 1'b0, resp_last_i = 1'b0, tx_char_done_i = 1'b0;
	reg [7:0] cmd_func_i = 8'h00;
	reg [1:0] cmd_class_i = 2'h0, ctl_mode_i = 2'h0;
	reg [15:0] status_addr_i = 16'h0000, exp_msg = 16'h0000, exp_evt = 16'h0000;
	wire rx_char_i, rx_frm_err_i, rx_addr_ok_i, line_idle_i, rx_en_o, tx_en_o, rts_o, tx_start_o;
	wire slot_req_o, single_slot_o, access_ok_o, log_valid_o;
	wire [7:0] rx_data_i, resp_func_o, status_data_o, log_data_o;
	wire [15:0] busy_word_o, msg_cnt_o, evt_cnt_o, crc_o;
	integer num_errors = 0, total_checks = 0, i;
	reg [7:0] lg_exp [0:63];
	reg [7:0] lg [0:63];
	reg [5:0] wp = 6'h00;
	always #5 clk_i = ~clk_i;
	sst_slave_tracker #(.CHAR_CYC(CC)) sst_slave_tracker_inst (.*, .rx_par_err_i(1'b0), .rx_ovr_err_i(1'b0));
	sst_host_model #(.CHAR_CYC(CC)) sst_host_model_inst (.clk_i(clk_i), .rx_char_o(rx_char_i),
		.rx_data_o(rx_data_i), .frm_err_o(rx_frm_err_i), .addr_ok_o(rx_addr_ok_i), .line_idle_o(line_idle_i));
	task chk(input string nm, input [15:0] got, input [15:0] exp);
		begin
			total_checks = total_checks + 1;
			if (got !== exp) begin
				num_errors = num_errors + 1;
				$display("[ERR] %s expected %h seen %h", nm, exp, got);
			end
		end
	endtask
	task put(input [7:0] v);
		begin
			lg_exp[wp] = v;
			wp = wp + 6'h01;
		end
	endtask
	task msg(input [7:0] f, input [2:0] ep, input aok);
		begin
			sst_host_model_inst.send(8'h11, f, ep, aok);
			for (i = 0; i < 4; i = i + 1)
				put({1'b0, !aok, 4'h0, ep == i, 1'b0});
		end
	endtask
	task slot;
		begin
			@(negedge clk_i) scan_access_slot_i = 1'b1;
			@(negedge clk_i) scan_access_slot_i = 1'b0;
			@(negedge clk_i) chk("busy", busy_word_o, 16'hffff);
			slot_done_i = 1'b1;
			@(negedge clk_i) slot_done_i = 1'b0;
		end
	endtask
	// slot count ns, gate result ok, decode error bd
	task xchg(input [7:0] f, input [1:0] c, input w, input [1:0] m, input integer ns, input ok, input bd);
		integer n;
		integer k;
		reg [5:0] ix;
		begin
			cmd_func_i = f;
			cmd_class_i = c;
			cmd_write_i = w;
			cmd_single_wr_i = w;
			cmd_read_i = !w && ns == 3;
			cmd_bad_i = bd;
			ctl_mode_i = m;
			access_ok_i = ok;
			msg(f, 3'h4, 1'b1);
			exp_msg = exp_msg + 16'h0001;
			for (n = 0; n < 99 && rx_en_o !== 1'b0; n = n + 1)
				@(negedge clk_i);
			repeat (2) @(negedge clk_i);
			chk("rx off", rx_en_o, 1'b0);
			chk("msg cnt", msg_cnt_o, exp_msg);
			chk("one slot", single_slot_o, ns == 1);
			repeat (ns) slot();
			if (ok && !bd && ns == 3)
				exp_evt = exp_evt + 16'h0001;
			repeat (2) @(negedge clk_i);
			if (!bd)
				chk("gate", access_ok_o, ok);
			chk("resp", resp_func_o, {!ok || bd, f[6:0]});
			chk("evt cnt", evt_cnt_o, exp_evt);
			chk("rts", rts_o, 1'b1);
			k = 0;
			for (n = 0; n < 999 && tx_start_o !== 1'b1; n = n + 1) begin
				if (log_valid_o === 1'b1) begin
					lg[k[5:0]] = log_data_o;
					k = k + 1;
				end
				@(negedge clk_i);
			end
			// the last log entry stands in the same cycle as the start pulse
			if (log_valid_o === 1'b1) begin
				lg[k[5:0]] = log_data_o;
				k = k + 1;
			end
			chk("tx on", tx_en_o, 1'b1);
			if (f == 8'h0c) begin
				chk("log len", k, 64);
				for (n = 0; n < 64; n = n + 1) begin
					ix = wp - 1 - n;
					chk("log", lg[n], lg_exp[ix]);
				end
			end
			@(negedge clk_i) tx_char_done_i = 1'b1;
			resp_last_i = 1'b1;
			put(8'h80);
			@(negedge clk_i) tx_char_done_i = 1'b0;
			for (n = 0; n < 99 && rts_o !== 1'b0; n = n + 1)
				@(negedge clk_i);
			chk("tail", n >= 4 * CC - 1 && n <= 4 * CC + 2, 1'b1);
			chk("rx on", {tx_en_o, rx_en_o}, 2'b01);
			resp_last_i = 1'b0;
			$display("exchange %h done", f);
		end
	endtask
	task fetch(input [15:0] a, input [7:0] e);
		begin
			@(negedge clk_i) status_fetch_operation_i = 1'b1;
			status_addr_i = a;
			@(negedge clk_i) status_fetch_operation_i = 1'b0;
			chk("status", status_data_o, e);
		end
	endtask
	task print_verdict;
		begin
			$display("checks %0d errors %0d", total_checks, num_errors);
			if (num_errors == 0 && total_checks > 0)
				$display("STATUS OK");
			else
				$display("STATUS NOT OK");
			$finish;
		end
	endtask
	initial begin
		for (i = 0; i < 64; i = i + 1)
			lg_exp[i] = 8'h00;
		repeat (8) @(negedge clk_i);
		rst_i = 1'b0;
		@(negedge clk_i);
		chk("crc preset", crc_o, 16'hffff);
		chk("counts", {msg_cnt_o[7:0], evt_cnt_o[7:0]}, 16'h0000);
		msg(8'h03, 3'h1, 1'b0);
		repeat (40) @(negedge clk_i);
		chk("bad msg", msg_cnt_o, exp_msg);
		chk("no reply", {slot_req_o, rx_en_o}, 2'b01);
		$display("bad message done");
		xchg(8'h03, 2'h1, 1'b0, 2'h2, 3, 1'b1, 1'b0);
		xchg(8'h05, 2'h2, 1'b1, 2'h1, 3, 1'b0, 1'b0);
		xchg(8'h04, 2'h1, 1'b0, 2'h0, 3, 1'b0, 1'b0);
		xchg(8'h02, 2'h0, 1'b0, 2'h0, 3, 1'b1, 1'b0);
		xchg(8'h06, 2'h3, 1'b1, 2'h1, 3, 1'b1, 1'b0);
		xchg(8'h03, 2'h0, 1'b0, 2'h2, 1, 1'b1, 1'b1);
		xchg(8'h08, 2'h3, 1'b0, 2'h0, 1, 1'b1, 1'b0);
		xchg(8'h0c, 2'h3, 1'b0, 2'h1, 1, 1'b1, 1'b0);
		fetch(16'h09c8, exp_msg[7:0]);
		fetch(16'h09c9, exp_msg[15:8]);
		fetch(16'h09ca, exp_evt[7:0]);
		fetch(16'h09cb, exp_evt[15:8]);
		fetch(16'h09cc, 8'h00);
		print_verdict;
	end
	// long enough for eight exchanges and a bad message with margin
	initial begin
		repeat (20000) @(posedge clk_i);
		num_errors = num_errors + 1;
		print_verdict;
	end
endmodule
